//--- core/adc_mux_cfg.svh
// Constants for the converter front-end configuration block
// Function
// R1: Upper four bits read zero, writes dropped
// R2: Pair bits 0-3 cover inputs 0/1..6/7
// R3: Set pair bit: even positive, odd negative
// R4: Differential results in two's complement
// R5: Low three select bits choose input
// R6: Select MSB set routes temperature sensor
// R7: Odd member of pair selects whole pair
// R8: Conversion clock is system clock over divider+1
// R9: Gain codes 1,2,4,8,16,16,0.5,0.5
// R10: Reset leaves all pairs single-ended
// R11: Outputs follow a write next clock edge
`ifndef ADC_MUX_CFG_SVH
`define ADC_MUX_CFG_SVH
`define PAIR_CFG_ADDR 8'hBA
`define CHAN_SEL_ADDR 8'hBB
`define CLK_GAIN_ADDR 8'hBC
`define PAIR_CFG_RESET 4'h0
`define CHAN_SEL_RESET 4'h0
`define CLK_GAIN_RESET 8'hF8
`define DIV_MSB 7
`define DIV_LSB 3
`define GAIN_MSB 2
`define GAIN_LSB 0
`define SEL_TEMP_BIT 3
`endif

//--- core/adc_mux_pkg.sv
// Types for the converter front-end configuration block
`default_nettype none
package adc_mux_pkg;
  typedef enum logic [2:0] {
    GAIN_X1 = 3'h0,
    GAIN_X2 = 3'h1,
    GAIN_X4 = 3'h2,
    GAIN_X8 = 3'h3,
    GAIN_X16 = 3'h4,
    GAIN_HALF = 3'h5
  } gain_sel_t;
endpackage
`default_nettype wire

//--- core/adc_input_mux_gain_config.sv
// Front-end register file and decode for the successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
`include "adc_mux_cfg.svh"
module adc_input_mux_gain_config #(
  parameter int DIV_WIDTH = 5
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Special-function register bus
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Analog selector controls
  output logic o_temp_select,
  output logic [2:0] o_pos_input,
  output logic [2:0] o_neg_input,
  output logic o_differential,
  output logic o_twos_complement,
  // Amplifier and clock
  output adc_mux_pkg::gain_sel_t o_gain,
  output logic [7:0] o_ampl_x2,
  output logic o_conversion_clock_en
);
  import adc_mux_pkg::*;

  // Divider field is fixed at five bits in the register map
  if (DIV_WIDTH != `DIV_MSB - `DIV_LSB + 1) begin : g_div_width_check
    $error("DIV_WIDTH must match the divider field");
  end

  // Stored register bits
  logic [3:0] pair_reg;
  logic [3:0] sel_reg;
  logic [7:0] cfg_reg;
  logic [DIV_WIDTH-1:0] div_cnt_reg;
  logic [DIV_WIDTH-1:0] div_cnt_next;

  // Bus decode
  logic pair_wr;
  logic sel_wr;
  logic cfg_wr;
  logic [7:0] pair_rd;
  logic [7:0] sel_rd;

  // Selector and amplifier decode
  logic [DIV_WIDTH-1:0] divider;
  logic [3:0] sel_code;
  logic pair_diff;
  logic sel_is_temp;
  logic [2:0] pair_base;
  logic temp_next;
  logic [2:0] pos_next;
  logic [2:0] neg_next;
  logic diff_next;
  gain_sel_t gain_next;
  logic [7:0] ampl_next;
  logic div_wrap;

  // Field views of the stored registers
  assign divider = cfg_reg[`DIV_MSB:`DIV_LSB];
  assign sel_code = sel_reg;

  // Write strobes, one per register; unmapped addresses are ignored
  assign pair_wr = i_sfr_wr && (i_sfr_addr == `PAIR_CFG_ADDR);
  assign sel_wr = i_sfr_wr && (i_sfr_addr == `CHAN_SEL_ADDR);
  assign cfg_wr = i_sfr_wr && (i_sfr_addr == `CLK_GAIN_ADDR);

  // Only the low nibble is stored; upper write bits are dropped
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pair_reg <= `PAIR_CFG_RESET; // R10
    end else if (pair_wr) begin
      pair_reg <= i_sfr_wdata[3:0]; // R1
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_reg <= `CHAN_SEL_RESET;
    end else if (sel_wr) begin
      sel_reg <= i_sfr_wdata[3:0]; // R1
    end
  end

  // Divider and gain share one byte, stored whole
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_reg <= `CLK_GAIN_RESET;
    end else if (cfg_wr) begin
      cfg_reg <= i_sfr_wdata;
    end
  end

  // Upper nibbles of the selector registers always read zero
  assign pair_rd = {4'h0, pair_reg}; // R1
  assign sel_rd = {4'h0, sel_reg}; // R1

  // Read mux, unmapped addresses read zero
  // Reads have no side effects, so any address may be polled
  always_comb begin
    unique case (i_sfr_addr)
      `PAIR_CFG_ADDR: o_sfr_rdata = pair_rd;
      `CHAN_SEL_ADDR: o_sfr_rdata = sel_rd;
      `CLK_GAIN_ADDR: o_sfr_rdata = cfg_reg;
      default: o_sfr_rdata = 8'h00;
    endcase
  end

  // Both codes of the top gain pairs give the same step
  function automatic gain_sel_t decode_gain(input logic [2:0] code);
    gain_sel_t g;
    g = GAIN_X1;
    unique case (code)
      3'h0: g = GAIN_X1; // R9
      3'h1: g = GAIN_X2;
      3'h2: g = GAIN_X4;
      3'h3: g = GAIN_X8;
      3'h4, 3'h5: g = GAIN_X16;
      3'h6, 3'h7: g = GAIN_HALF;
    endcase
    decode_gain = g;
  endfunction

  // Gain expressed in half steps so 0.5 stays an integer
  function automatic logic [7:0] gain_halves(input gain_sel_t g);
    logic [7:0] h;
    h = 8'h02;
    unique case (g)
      GAIN_X1: h = 8'h02;
      GAIN_X2: h = 8'h04;
      GAIN_X4: h = 8'h08;
      GAIN_X8: h = 8'h10;
      GAIN_X16: h = 8'h20;
      GAIN_HALF: h = 8'h01;
      default: h = 8'h02;
    endcase
    gain_halves = h;
  endfunction

  assign pair_diff = pair_reg[sel_code[2:1]]; // R2

  // Temperature code and pair base taken from the select code
  assign sel_is_temp = sel_code[`SEL_TEMP_BIT];
  assign pair_base = {sel_code[2:1], 1'b0};
  assign gain_next = decode_gain(cfg_reg[`GAIN_MSB:`GAIN_LSB]); // R9
  assign ampl_next = gain_halves(gain_next);

  // Selector decode
  always_comb begin
    if (sel_is_temp) begin
      // Sensor wins regardless of pairing
      temp_next = 1'b1; // R6
      pos_next = 3'h0;
      neg_next = 3'h0;
      diff_next = 1'b0;
    end else if (pair_diff) begin
      // Odd code folds onto its pair, even side positive
      temp_next = 1'b0;
      pos_next = pair_base; // R3 R7
      neg_next = pair_base | 3'h1; // R3
      diff_next = 1'b1;
    end else begin
      temp_next = 1'b0;
      pos_next = sel_code[2:0]; // R5
      neg_next = 3'h0;
      diff_next = 1'b0;
    end
  end

  // Registered decode: outputs change the edge after the write lands
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_temp_select <= 1'b0;
      o_pos_input <= 3'h0;
      o_neg_input <= 3'h0;
      o_differential <= 1'b0;
      o_twos_complement <= 1'b0;
    end else begin
      o_temp_select <= temp_next;
      o_pos_input <= pos_next;
      o_neg_input <= neg_next;
      o_differential <= diff_next;
      o_twos_complement <= diff_next; // R4
    end
  end

  // Amplifier outputs kept apart from the selector path
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_gain <= GAIN_X1;
      o_ampl_x2 <= 8'h02;
    end else begin
      o_gain <= gain_next; // R9 R11
      o_ampl_x2 <= ampl_next; // R9
    end
  end

  // Enable pulse every divider+1 system clocks; a smaller new divider
  // cuts the running period short, a larger one stretches it
  assign div_wrap = (div_cnt_reg >= divider); // R8
  assign div_cnt_next = div_wrap ? '0 : div_cnt_reg + DIV_WIDTH'(1);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_next; // R8
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_conversion_clock_en <= 1'b0;
    end else begin
      o_conversion_clock_en <= div_wrap;
    end
  end
endmodule // adc_input_mux_gain_config
`default_nettype wire

//--- bench/conv_clock_sink.sv
// Divider consumer that times conversion clock pulses
`timescale 1ns/1ps
`default_nettype none
module conv_clock_sink (
  input wire logic i_clk,
  input wire logic i_en,
  output logic [7:0] o_gap
);
  logic [7:0] cnt_reg;
  always_ff @(posedge i_clk) begin
    cnt_reg <= i_en ? 8'h01 : cnt_reg + 8'h01;
    if (i_en) o_gap <= cnt_reg;
  end
endmodule // conv_clock_sink
`default_nettype wire

//--- bench/adc_mux_cfg_assertions.sv
// Port assertions for the front-end configuration block
`timescale 1ns/1ps
`default_nettype none
module adc_mux_cfg_chk (
  input wire logic i_clk, i_rstn, i_sfr_wr, o_temp_select, o_differential, o_twos_complement,
  input wire logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, o_ampl_x2,
  input wire logic [2:0] o_pos_input, o_neg_input,
  input wire adc_mux_pkg::gain_sel_t o_gain
);
  import adc_mux_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence wr_to(a); i_sfr_wr && i_sfr_addr == a; endsequence
  function automatic gain_sel_t gexp(logic [2:0] c);
    return c[2] ? (c[1] ? GAIN_HALF : GAIN_X16) : gain_sel_t'(c);
  endfunction
  upper_zero_a: assert property (i_sfr_addr inside {8'hBA, 8'hBB} |->
    o_sfr_rdata[7:4] == 4'h0) else $error("upper bits set");
  pair_read_a: assert property (wr_to(8'hBA) ##1 i_sfr_addr == 8'hBA |->
    o_sfr_rdata == {4'h0, $past(i_sfr_wdata[3:0])}) else $error("pair readback");
  temp_route_a: assert property (wr_to(8'hBB) |-> ##2
    o_temp_select == $past(i_sfr_wdata[3], 2)) else $error("temp select");
  gain_write_a: assert property (wr_to(8'hBC) |-> ##2
    o_gain == gexp($past(i_sfr_wdata[2:0], 2))) else $error("gain decode");
  twos_diff_a: assert property (o_twos_complement == o_differential)
    else $error("format");
  diff_pair_a: assert property (o_differential |-> !o_pos_input[0] &&
    o_neg_input == o_pos_input + 3'h1) else $error("pair order");
  ampl_map_a: assert property (o_ampl_x2 ==
    (o_gain == GAIN_HALF ? 8'h01 : 8'h02 << o_gain)) else $error("gain value");
  reset_state_a: assert property ($rose(i_rstn) |-> o_gain == GAIN_X1 &&
    !o_differential && !o_temp_select) else $error("reset state");
endmodule // adc_mux_cfg_chk
bind adc_input_mux_gain_config adc_mux_cfg_chk i_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_sfr_wr(i_sfr_wr), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
  .o_sfr_rdata(o_sfr_rdata), .o_temp_select(o_temp_select), .o_differential(o_differential),
  .o_twos_complement(o_twos_complement), .o_ampl_x2(o_ampl_x2), .o_pos_input(o_pos_input),
  .o_neg_input(o_neg_input), .o_gain(o_gain));
`default_nettype wire

//--- bench/adc_input_mux_gain_config_bench.sv
// Self-checking bench for the front-end configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
  $display("CHECK FAILED %0t mismatch", $time); end end
module adc_input_mux_gain_config_bench;
  import adc_mux_pkg::*;
  logic i_clk = 0, i_rstn = 0, i_sfr_wr = 0;
  logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, o_sfr_rdata, o_ampl_x2, gap;
  logic o_temp_select, o_differential, o_twos_complement, o_conversion_clock_en;
  logic [2:0] o_pos_input, o_neg_input;
  gain_sel_t o_gain;
  int err_total = 0, checks = 0, cyc = 0;
  adc_input_mux_gain_config i_dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .o_temp_select(o_temp_select),
    .o_pos_input(o_pos_input), .o_neg_input(o_neg_input),
    .o_differential(o_differential), .o_twos_complement(o_twos_complement),
    .o_gain(o_gain), .o_ampl_x2(o_ampl_x2),
    .o_conversion_clock_en(o_conversion_clock_en));
  conv_clock_sink i_sink (.i_clk(i_clk), .i_en(o_conversion_clock_en), .o_gap(gap));
  initial forever #5 i_clk = ~i_clk;
  always @(posedge i_clk) if (++cyc == 2000) begin err_total++; wrap_up(); end
  task wrap_up;
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Strobe is dropped for an edge so decode has settled on return
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk); #1 i_sfr_addr = a; i_sfr_wdata = d; i_sfr_wr = 1;
    @(posedge i_clk); #1 i_sfr_wr = 0;
    @(posedge i_clk); #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk); #1 i_sfr_addr = a;
    #4 `CHK(o_sfr_rdata, e)
  endtask
  task pulses(input logic [7:0] n);
    repeat (3) @(posedge o_conversion_clock_en);
    @(posedge i_clk); #1 `CHK(gap, n)
  endtask
  task t_reset;
    rd(8'hBA, 8'h00);
    rd(8'hBB, 8'h00);
    rd(8'hBC, 8'hF8);
    `CHK({o_differential, o_twos_complement, o_temp_select}, 3'h0)
    `CHK(o_ampl_x2, 8'h02)
    pulses(8'd32);
    $display("reset test done");
  endtask
  task t_regs;
    wr(8'hBA, 8'hFF); rd(8'hBA, 8'h0F);
    wr(8'h55, 8'h12); rd(8'h55, 8'h00); rd(8'hBC, 8'hF8);
    wr(8'hBB, 8'hF9); rd(8'hBB, 8'h09); `CHK(o_temp_select, 1'b1)
    wr(8'hBB, 8'h03);
    `CHK({o_differential, o_twos_complement, o_pos_input, o_neg_input}, 8'hD3)
    wr(8'hBA, 8'h00);
    `CHK({o_differential, o_twos_complement, o_pos_input, o_neg_input}, 8'h18)
    $display("mux test done");
  endtask
  task t_gain;
    gain_sel_t gx [8];
    logic [7:0] hx [8];
    gx = '{GAIN_X1, GAIN_X2, GAIN_X4, GAIN_X8, GAIN_X16, GAIN_X16, GAIN_HALF, GAIN_HALF};
    hx = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h20, 8'h01, 8'h01};
    for (int g = 0; g < 8; g++) begin
      wr(8'hBC, {5'd1, g[2:0]});
      `CHK(o_gain, gx[g])
      `CHK(o_ampl_x2, hx[g])
    end
    pulses(8'd2);
    $display("gain test done");
  endtask
  // Mid-run reset must drop every setting back to its reset value
  task t_rerun;
    wr(8'hBA, 8'h0F); wr(8'hBB, 8'h04); wr(8'hBC, 8'h1C);
    `CHK({o_differential, o_pos_input, o_neg_input}, 7'h65)
    `CHK(o_ampl_x2, 8'h20)
    @(posedge i_clk); #1 i_rstn = 0;
    repeat (5) @(posedge i_clk);
    #1 i_rstn = 1;
    rd(8'hBA, 8'h00);
    rd(8'hBB, 8'h00);
    rd(8'hBC, 8'hF8);
    `CHK({o_differential, o_temp_select, o_pos_input}, 5'h00)
    `CHK(o_gain, GAIN_X1)
    $display("rerun test done");
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    #1 i_rstn = 1;
    t_reset;
    t_regs;
    t_gain;
    t_rerun;
    wrap_up;
  end
endmodule // adc_input_mux_gain_config_bench
`default_nettype wire
